/* core/pan_autoneg.sv */
// Auto-negotiation control with Wishbone register file
// Contract
// - Start negotiation at power-up, on link loss and on returning energy.
// - With power management on, MAC low-power entry restarts negotiation.
// - Copper: release of the MAC-driven PHY hard reset starts negotiation.
// - Copper: soft reset, restart, or power-down exit starts negotiation.
// - Fiber: link reset with fiber autoneg enable set starts negotiation.
// - Reset defaults advertise full gigabit and resolve best common mode.
// - Copper partner without negotiation: parallel detect 100 or 10 only.
// - Software options kept only while LAN power is good.
// - Fiber with negotiation off forces 1000 full duplex.
// - Gigabit advertised: automatic next page sent for capability.
// - Next page bit cleared means no extra pages, no software work.
// - Expansion bit 15 set: exchange extra pages via transmit register.
// - Earlier partner next pages kept internally before overwrite.
// - Deferred control bits apply only at reset, restart, wake, link down.
// - Fiber autoneg enable cleared disables fiber negotiation.
// - Expansion and gigabit control latched on entering ability detect.
// - Next page transmit word latched the same way during extra pages.
// - On completion update status, partner ability, expansion, gig status.
// - Speed, duplex, page received, complete in specific and int status.
// - Fiber link state shown in MAC status.
// - MAC status speed, duplex, link updated shortly after completion.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
module pan_autoneg
	import pan_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// System
	input wire logic lan_power_ok_i,
	input wire logic fiber_mode_i,
	input wire logic mac_low_power_i,
	// Link partner side
	input wire pan_pkg::pan_link_in_t link_i,
	output pan_pkg::pan_link_out_t link_o
);
	import pan_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] bytes_wr(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = d[7:0];
		if (sel[1])
			r[15:8] = d[15:8];
		return r;
	endfunction

	function automatic logic [2:0] resolve(input logic [15:0] common,
		input logic gig);
		logic [2:0] r;
		r = {SPD_10, 1'b0};
		if (gig)
			r = {SPD_1000, 1'b1};
		else if (common[ADV_100FD])
			r = {SPD_100, 1'b1};
		else if (common[ADV_100HD])
			r = {SPD_100, 1'b0};
		else if (common[ADV_10FD])
			r = {SPD_10, 1'b1};
		return r;
	endfunction

	// ==========================================================
	// Declarations
	pan_state_t state_reg, state_next;
	logic [15:0] ctrl_reg, adv_reg, exp_reg, npt_reg, gctl_reg, psctl_reg;
	logic [15:0] fiber_tx_config_word_reg;
	logic [2:0] mctl_reg;
	logic [15:0] ctrl_act_reg, psctl_act_reg;
	logic [15:0] adv_lat_reg, exp_lat_reg, gctl_lat_reg, npt_lat_reg;
	logic [15:0] lpa_reg, lpnp_reg, gstat_reg;
	logic [15:0] np_hist_reg [NP_HIST_DEPTH];
	logic [1:0] np_hist_sel_reg;
	logic an_done_reg, page_rx_reg, link_reg;
	logic [1:0] spd_reg;
	logic fd_reg;
	logic [3:0] pint_reg;
	logic [3:0] mstat_reg;
	logic [7:0] mdly_reg;
	logic mdly_run_reg;
	logic energy_q_reg, link_q_reg, lowp_q_reg, hrst_q_reg;
	logic init_reg;
	logic wb_req, wr_req;
	logic [2:0] res;
	logic copper, soft_rst_wr, restart_wr, pwr_exit_wr, fiber_start_wr;
	logic link_lost, trigger, apply_defer, fiber_an_on;
	logic start_pend_reg, go;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_req = wb_req && wb_we_i;
	assign copper = !fiber_mode_i;
	assign fiber_an_on = fiber_tx_config_word_reg[FIBER_AUTONEG_ENABLE];

	// ==========================================================
	// Start events
	always_comb
	begin
		soft_rst_wr = wr_req && wb_adr_i == OFS_CTRL && wb_sel_i[1] &&
			wb_dat_i[CTRL_SOFT_RST] && copper;
		restart_wr = wr_req && wb_adr_i == OFS_CTRL && wb_sel_i[1] &&
			wb_dat_i[CTRL_RESTART] && copper;
		pwr_exit_wr = wr_req && wb_adr_i == OFS_CTRL && wb_sel_i[1] &&
			ctrl_reg[CTRL_PWR_DOWN] && !wb_dat_i[CTRL_PWR_DOWN] && copper;
		fiber_start_wr = wr_req && wb_adr_i == OFS_MCTL && wb_sel_i[0] &&
			wb_dat_i[MCTL_LINK_RST] && fiber_an_on && fiber_mode_i;
		link_lost = link_q_reg && !link_i.link_ok;
		trigger = init_reg
			|| link_lost
			|| (link_i.energy && !energy_q_reg)
			|| (mac_low_power_i && !lowp_q_reg &&
			mctl_reg[MCTL_PM_EN])
			|| (hrst_q_reg && !mctl_reg[MCTL_HARD_RST] && copper)
			|| soft_rst_wr || restart_wr || pwr_exit_wr
			|| fiber_start_wr;
		apply_defer = soft_rst_wr || restart_wr || pwr_exit_wr ||
			link_lost;
		go = trigger || start_pend_reg;
	end

	// ==========================================================
	// Edge history and power-up start
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			energy_q_reg <= 1'b0;
			link_q_reg <= 1'b0;
			lowp_q_reg <= 1'b0;
			hrst_q_reg <= 1'b0;
			init_reg <= 1'b1;
			start_pend_reg <= 1'b0;
		end
		else
		begin
			energy_q_reg <= link_i.energy;
			link_q_reg <= link_i.link_ok;
			lowp_q_reg <= mac_low_power_i;
			hrst_q_reg <= mctl_reg[MCTL_HARD_RST];
			init_reg <= 1'b0;
			start_pend_reg <= state_reg != ST_IDLE &&
				state_next == ST_IDLE;
		end
	end

	// ==========================================================
	// Software registers, cleared to defaults on power loss
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			ctrl_reg <= CTRL_RESET;
			adv_reg <= ADV_RESET;
			exp_reg <= EXP_RESET;
			npt_reg <= NPT_RESET;
			gctl_reg <= GCTL_RESET;
			psctl_reg <= PSCTL_RESET;
			fiber_tx_config_word_reg <= FIBER_TX_CONFIG_WORD_RESET;
			mctl_reg <= MCTL_RESET;
		end
		else
		begin
			if (wr_req)
			begin
				case (wb_adr_i)
					OFS_CTRL: ctrl_reg <= bytes_wr(ctrl_reg, wb_dat_i, wb_sel_i);
					OFS_ADV: adv_reg <= bytes_wr(adv_reg, wb_dat_i, wb_sel_i);
					OFS_EXP: exp_reg <= bytes_wr(exp_reg, wb_dat_i, wb_sel_i);
					OFS_NPT: npt_reg <= bytes_wr(npt_reg, wb_dat_i, wb_sel_i);
					OFS_GCTL: gctl_reg <= bytes_wr(gctl_reg, wb_dat_i, wb_sel_i);
					OFS_PSCTL: psctl_reg <= bytes_wr(psctl_reg, wb_dat_i, wb_sel_i);
					OFS_FIBER_TX_CONFIG_WORD: fiber_tx_config_word_reg <= bytes_wr(fiber_tx_config_word_reg, wb_dat_i, wb_sel_i);
					OFS_MCTL:
					begin
						if (wb_sel_i[0])
							mctl_reg <= wb_dat_i[2:0];
					end
					default:
					begin
					end
				endcase
			end
			if (state_reg == ST_IDLE && go)
			begin
				ctrl_reg[CTRL_SOFT_RST] <= 1'b0;
				ctrl_reg[CTRL_RESTART] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Deferred control copies
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			ctrl_act_reg <= CTRL_RESET;
			psctl_act_reg <= PSCTL_RESET;
		end
		else if (apply_defer)
		begin
			ctrl_act_reg <= ((soft_rst_wr || restart_wr || pwr_exit_wr) ?
				bytes_wr(ctrl_reg, wb_dat_i, wb_sel_i) : ctrl_reg) &
				CTRL_DEFER_MASK;
			psctl_act_reg <= psctl_reg & PSCTL_DEFER_MASK;
		end
	end

	// ==========================================================
	// Arbitration state machine
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (go)
				begin
					if (fiber_mode_i && !fiber_an_on)
						state_next = ST_PDETECT;
					else if (copper && !ctrl_act_reg[CTRL_AN_EN])
						state_next = ST_PDETECT;
					else
						state_next = ST_ABILITY;
				end
			end
			ST_ABILITY:
			begin
				if (link_i.base_valid)
				begin
					if (copper && gctl_lat_reg[GIG_FD:GIG_FD - 1] != 2'h0)
						state_next = ST_AUTO_NP;
					else if (exp_lat_reg[EXP_EXTRA_NP] &&
						adv_lat_reg[ADV_NEXT_PAGE])
						state_next = ST_EXTRA_NP;
					else
						state_next = ST_DONE;
				end
				else if (!link_i.partner_an && link_i.link_ok)
					state_next = ST_PDETECT;
			end
			ST_AUTO_NP:
			begin
				if (link_i.page_valid)
				begin
					if (exp_lat_reg[EXP_EXTRA_NP] && adv_lat_reg[ADV_NEXT_PAGE])
						state_next = ST_EXTRA_NP;
					else
						state_next = ST_DONE;
				end
			end
			ST_EXTRA_NP:
			begin
				if (link_i.page_valid && !npt_lat_reg[NP_MORE])
					state_next = ST_DONE;
			end
			ST_DONE:
				state_next = ST_LINK_UP;
			ST_PDETECT:
			begin
				if (link_i.link_ok)
					state_next = ST_LINK_UP;
			end
			ST_LINK_UP:
			begin
				if (trigger)
					state_next = ST_IDLE;
			end
			default:
				state_next = ST_IDLE;
		endcase
		if (state_reg != ST_IDLE && state_reg != ST_LINK_UP &&
			(link_lost || soft_rst_wr || restart_wr))
			state_next = ST_IDLE;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Latches taken on entry to ability detect, next page transmit word on entry to and during extra pages
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			adv_lat_reg <= ADV_RESET;
			exp_lat_reg <= EXP_RESET;
			gctl_lat_reg <= GCTL_RESET;
			npt_lat_reg <= NPT_RESET;
		end
		else
		begin
			if (state_next == ST_ABILITY && state_reg != ST_ABILITY)
			begin
				adv_lat_reg <= adv_reg;
				exp_lat_reg <= exp_reg;
				gctl_lat_reg <= gctl_reg;
			end
			if (state_next == ST_EXTRA_NP &&
				(state_reg != ST_EXTRA_NP || link_i.page_valid))
				npt_lat_reg <= npt_reg;
		end
	end

	// ==========================================================
	// Partner pages and next page history
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			lpa_reg <= 16'h0000;
			lpnp_reg <= 16'h0000;
			gstat_reg <= 16'h0000;
			np_hist_sel_reg <= 2'h0;
			for (int i = 0; i < NP_HIST_DEPTH; i++)
				np_hist_reg[i] <= 16'h0000;
		end
		else
		begin
			if (state_reg == ST_ABILITY && link_i.base_valid)
				lpa_reg <= link_i.base_word;
			if (state_reg == ST_AUTO_NP && link_i.page_valid)
				gstat_reg <= link_i.page_word & gctl_lat_reg;
			if (state_reg == ST_EXTRA_NP && link_i.page_valid)
			begin
				lpnp_reg <= link_i.page_word;
				np_hist_reg[0] <= lpnp_reg;
				for (int i = 1; i < NP_HIST_DEPTH; i++)
					np_hist_reg[i] <= np_hist_reg[i - 1];
			end
			if (wr_req && wb_adr_i == OFS_NPHIST && wb_sel_i[0])
				np_hist_sel_reg <= wb_dat_i[1:0];
		end
	end

	// ==========================================================
	// Resolution and status
	assign res = resolve(adv_lat_reg & lpa_reg, gstat_reg[GIG_FD]);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			an_done_reg <= 1'b0;
			page_rx_reg <= 1'b0;
			link_reg <= 1'b0;
			spd_reg <= SPD_10;
			fd_reg <= 1'b0;
			pint_reg <= 4'h0;
		end
		else
		begin
			if (wr_req && wb_adr_i == OFS_PINT && wb_sel_i[0])
				pint_reg <= pint_reg & ~wb_dat_i[3:0];
			if (state_reg == ST_IDLE && go)
			begin
				an_done_reg <= 1'b0;
				page_rx_reg <= 1'b0;
			end
			if (link_i.base_valid || link_i.page_valid)
			begin
				page_rx_reg <= 1'b1;
				pint_reg[1] <= 1'b1;
			end
			if (state_reg == ST_DONE)
			begin
				an_done_reg <= 1'b1;
				spd_reg <= fiber_mode_i ? SPD_1000 : res[2:1];
				fd_reg <= res[0] || fiber_mode_i;
				pint_reg[0] <= 1'b1;
				pint_reg[3:2] <= {1'b1, 1'b1};
			end
			else if (state_reg == ST_PDETECT && link_i.link_ok)
			begin
				if (fiber_mode_i)
				begin
					spd_reg <= SPD_1000;
					fd_reg <= 1'b1;
				end
				else if (!ctrl_act_reg[CTRL_AN_EN])
				begin
					spd_reg <= {ctrl_act_reg[CTRL_SPD_MSB],
						ctrl_act_reg[CTRL_SPD_LSB]};
					fd_reg <= ctrl_act_reg[CTRL_DUPLEX];
				end
				else
				begin
					spd_reg <= (link_i.partner_speed == SPD_100) ?
						SPD_100 : SPD_10;
					fd_reg <= 1'b0;
				end
				pint_reg[3:2] <= {1'b1, 1'b1};
			end
			link_reg <= state_reg == ST_LINK_UP && link_i.link_ok;
		end
	end

	// ==========================================================
	// MAC status, updated after a short delay
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !lan_power_ok_i)
		begin
			mstat_reg <= 4'h0;
			mdly_reg <= 8'h00;
			mdly_run_reg <= 1'b0;
		end
		else
		begin
			if (!link_reg)
			begin
				mstat_reg[0] <= 1'b0;
				mdly_run_reg <= 1'b0;
			end
			else if (!mstat_reg[0] && !mdly_run_reg)
			begin
				mdly_run_reg <= 1'b1;
				mdly_reg <= 8'(MSTAT_DELAY_CYC);
			end
			else if (mdly_run_reg && mdly_reg != 8'h00)
				mdly_reg <= mdly_reg - 8'h01;
			else if (mdly_run_reg)
			begin
				mstat_reg <= {spd_reg, fd_reg, 1'b1};
				mdly_run_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Link outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			link_o <= '0;
		else
		begin
			link_o.flp_active <= state_reg == ST_ABILITY ||
				state_reg == ST_AUTO_NP || state_reg == ST_EXTRA_NP;
			link_o.tx_valid <= state_reg == ST_ABILITY ||
				state_reg == ST_AUTO_NP || state_reg == ST_EXTRA_NP;
			case (state_reg)
				ST_ABILITY: link_o.tx_word <= fiber_mode_i ?
					fiber_tx_config_word_reg : adv_lat_reg;
				ST_AUTO_NP: link_o.tx_word <= gctl_lat_reg;
				ST_EXTRA_NP: link_o.tx_word <= npt_lat_reg;
				default: link_o.tx_word <= 16'h0000;
			endcase
			link_o.speed <= mstat_reg[3:2];
			link_o.full_duplex <= mstat_reg[1];
			link_o.link_up <= mstat_reg[0];
		end
	end

	// ==========================================================
	// Wishbone read and acknowledge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i)
			begin
				case (wb_adr_i)
					OFS_CTRL: wb_dat_o <= {16'h0000, ctrl_reg};
					OFS_STAT: wb_dat_o <= {26'h0, an_done_reg, 2'h0,
						link_reg, 2'h0};
					OFS_ADV: wb_dat_o <= {16'h0000, adv_reg};
					OFS_LPA: wb_dat_o <= {16'h0000, lpa_reg};
					OFS_EXP: wb_dat_o <= {16'h0000, exp_reg[15:2],
						page_rx_reg, 1'b0};
					OFS_NPT: wb_dat_o <= {16'h0000, npt_reg};
					OFS_LPNP: wb_dat_o <= {16'h0000, lpnp_reg};
					OFS_GCTL: wb_dat_o <= {16'h0000, gctl_reg};
					OFS_GSTAT: wb_dat_o <= {16'h0000, gstat_reg};
					OFS_PSCTL: wb_dat_o <= {16'h0000, psctl_reg};
					OFS_PSSTAT: wb_dat_o <= {26'h0, spd_reg, fd_reg,
						page_rx_reg, an_done_reg, link_reg};
					OFS_PINT: wb_dat_o <= {28'h0, pint_reg};
					OFS_MCTL: wb_dat_o <= {29'h0, mctl_reg};
					OFS_FIBER_TX_CONFIG_WORD: wb_dat_o <= {16'h0000, fiber_tx_config_word_reg};
					OFS_FIBER_RX_CONFIG_WORD: wb_dat_o <= {16'h0000, link_i.rx_config_word};
					OFS_MSTAT: wb_dat_o <= {28'h0, mstat_reg};
					OFS_NPHIST: wb_dat_o <= {16'h0000,
						np_hist_reg[np_hist_sel_reg]};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

/* core/pan_pkg.sv */
// Package with offsets, fields, defaults and carriers of the negotiation block
package pan_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_ADV = 8'h08;
	localparam logic [7:0] OFS_LPA = 8'h0c;
	localparam logic [7:0] OFS_EXP = 8'h10;
	localparam logic [7:0] OFS_NPT = 8'h14;
	localparam logic [7:0] OFS_LPNP = 8'h18;
	localparam logic [7:0] OFS_GCTL = 8'h1c;
	localparam logic [7:0] OFS_GSTAT = 8'h20;
	localparam logic [7:0] OFS_PSCTL = 8'h24;
	localparam logic [7:0] OFS_PSSTAT = 8'h28;
	localparam logic [7:0] OFS_PINT = 8'h2c;
	localparam logic [7:0] OFS_MCTL = 8'h30;
	localparam logic [7:0] OFS_FIBER_TX_CONFIG_WORD = 8'h34;
	localparam logic [7:0] OFS_FIBER_RX_CONFIG_WORD = 8'h38;
	localparam logic [7:0] OFS_MSTAT = 8'h3c;
	localparam logic [7:0] OFS_NPHIST = 8'h40;
	// ==========================================================
	// Field positions
	localparam int CTRL_SOFT_RST = 15;
	localparam int CTRL_AN_EN = 12;
	localparam int CTRL_PWR_DOWN = 11;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_SPD_LSB = 13;
	localparam int CTRL_SPD_MSB = 6;
	localparam int CTRL_DUPLEX = 8;
	localparam int ADV_NEXT_PAGE = 15;
	localparam int EXP_EXTRA_NP = 15;
	localparam int NP_MORE = 15;
	localparam int MCTL_PM_EN = 0;
	localparam int MCTL_HARD_RST = 1;
	localparam int MCTL_LINK_RST = 2;
	localparam int FIBER_AUTONEG_ENABLE = 15;
	localparam int STAT_LINK = 2;
	localparam int STAT_AN_DONE = 5;
	localparam int EXP_PAGE_RX = 1;
	localparam int ADV_10HD = 5;
	localparam int ADV_10FD = 6;
	localparam int ADV_100HD = 7;
	localparam int ADV_100FD = 8;
	localparam int GIG_FD = 9;
	// Deferred control bits in the control and specific control words
	localparam logic [15:0] CTRL_DEFER_MASK = 16'h3140;
	localparam logic [15:0] PSCTL_DEFER_MASK = 16'h0b78;
	// ==========================================================
	// Reset values: full gigabit copper and fiber advertisement
	localparam logic [15:0] CTRL_RESET = 16'h1140;
	localparam logic [15:0] ADV_RESET = 16'h81e1;
	localparam logic [15:0] EXP_RESET = 16'h0000;
	localparam logic [15:0] GCTL_RESET = 16'h0300;
	localparam logic [15:0] PSCTL_RESET = 16'h0068;
	localparam logic [15:0] FIBER_TX_CONFIG_WORD_RESET = 16'ha020;
	localparam logic [15:0] NPT_RESET = 16'h0001;
	localparam logic [2:0] MCTL_RESET = 3'h0;
	// ==========================================================
	// Speed codes
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	// ==========================================================
	// Timing: delay from negotiation end to MAC status update
	localparam int CLK_MHZ = 125;
	localparam int MSTAT_DELAY_NS = 24;
	localparam int MSTAT_DELAY_CYC = (MSTAT_DELAY_NS * CLK_MHZ) / 1000;
	localparam int NP_HIST_DEPTH = 4;
	// ==========================================================
	// Arbitration states, Gray coded along the path through extra next pages
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ABILITY = 3'h1,
		ST_AUTO_NP = 3'h3,
		ST_EXTRA_NP = 3'h2,
		ST_DONE = 3'h6,
		ST_LINK_UP = 3'h7,
		ST_PDETECT = 3'h5
	} pan_state_t;
	// ==========================================================
	// Link side carriers
	typedef struct packed {
		logic energy;
		logic link_ok;
		logic partner_an;
		logic [1:0] partner_speed;
		logic base_valid;
		logic [15:0] base_word;
		logic page_valid;
		logic [15:0] page_word;
		logic [15:0] rx_config_word;
	} pan_link_in_t;
	typedef struct packed {
		logic flp_active;
		logic tx_valid;
		logic [15:0] tx_word;
		logic [1:0] speed;
		logic full_duplex;
		logic link_up;
	} pan_link_out_t;
endpackage

/* testbench/pan_chk.sv */
// Port checker for the negotiation block, bound to its top
module pan_chk
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// System and link
	input wire logic lan_power_ok_i,
	input wire logic fiber_mode_i,
	input wire logic mac_low_power_i,
	input wire pan_pkg::pan_link_in_t link_i,
	input wire pan_pkg::pan_link_out_t link_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pan_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Properties
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack too long");
	property p_hi_zero;
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero)
		else $error("upper read bits set");
	property p_boot;
		$fell(rst_i) && !fiber_mode_i && lan_power_ok_i
			|-> ##[1:4] link_o.flp_active;
	endproperty
	a_boot: assert property (p_boot)
		else $error("no start after reset");
	property p_loss;
		!fiber_mode_i && link_o.link_up && $fell(link_i.link_ok)
			|-> ##[1:8] !link_o.link_up;
	endproperty
	a_loss: assert property (p_loss)
		else $error("link loss ignored");
	property p_fib;
		fiber_mode_i && link_o.link_up
			|-> link_o.speed == SPD_1000 && link_o.full_duplex;
	endproperty
	a_fib: assert property (p_fib)
		else $error("fiber not 1000 full");
	property p_pdet;
		$rose(link_o.link_up) && !link_i.partner_an && !fiber_mode_i
			|-> link_o.speed != SPD_1000;
	endproperty
	a_pdet: assert property (p_pdet)
		else $error("parallel detect gave 1000");
	property p_up;
		$rose(link_o.link_up) |-> link_i.link_ok && !link_o.flp_active;
	endproperty
	a_up: assert property (p_up)
		else $error("link up without cause");
	property p_pwr;
		$fell(lan_power_ok_i) |-> ##[1:3] !link_o.tx_valid;
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("pages sent after power loss");
	c_up: cover property ($rose(link_o.link_up));
	c_pdet: cover property (!link_i.partner_an && link_o.link_up);
	c_fib: cover property (fiber_mode_i && link_o.link_up);
endmodule
bind pan_autoneg pan_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.lan_power_ok_i(lan_power_ok_i), .fiber_mode_i(fiber_mode_i),
	.mac_low_power_i(mac_low_power_i), .link_i(link_i),
	.link_o(link_o));

/* testbench/pan_partner.sv */
// Behavioural remote link partner
module pan_partner
#(
	parameter logic [15:0] BASE_W = 16'h81e1,
	parameter logic [15:0] PAGE_W = 16'h0200,
	parameter logic [15:0] CFG_W = 16'h4020
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Scenario control
	input wire logic up_i,
	input wire logic an_i,
	input wire logic [1:0] spd_i,
	input wire logic [3:0] dly_i,
	// Device side
	input wire pan_pkg::pan_link_out_t dev_i,
	output pan_pkg::pan_link_in_t to_dev_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import pan_pkg::*;
	logic [3:0] cnt_reg;
	logic first_reg, base_reg, page_reg;
	logic [15:0] word_reg;
	// ==========================================================
	// One page every dly_i+1 cycles, word toggles between pages
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !dev_i.tx_valid || !an_i || !up_i)
		begin
			cnt_reg <= 4'h0;
			first_reg <= 1'b1;
			base_reg <= 1'b0;
			page_reg <= 1'b0;
			word_reg <= rst_i ? 16'h0 : ~word_reg;
		end
		else if (cnt_reg == dly_i)
		begin
			cnt_reg <= 4'h0;
			first_reg <= 1'b0;
			base_reg <= first_reg;
			page_reg <= !first_reg;
			word_reg <= first_reg ? BASE_W : PAGE_W;
		end
		else
		begin
			cnt_reg <= cnt_reg + 4'h1;
			base_reg <= 1'b0;
			page_reg <= 1'b0;
			word_reg <= ~word_reg;
		end
	end
	assign to_dev_o = '{up_i, up_i, an_i, spd_i, base_reg, word_reg,
		page_reg, word_reg, CFG_W};
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the negotiation block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pan_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, pwr, fib, lowp, up, an;
	logic [7:0] adr;
	logic [3:0] sel, dly;
	logic [31:0] dat, rdat, q;
	logic [1:0] spd;
	pan_link_in_t lk_i;
	pan_link_out_t lk_o;
	int mismatches, n_compared;
	pan_autoneg uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.lan_power_ok_i(pwr), .fiber_mode_i(fib),
		.mac_low_power_i(lowp), .link_i(lk_i), .link_o(lk_o));
	pan_partner u_lp (.clk_i(clk_i), .rst_i(rst_i), .up_i(up), .an_i(an),
		.spd_i(spd), .dly_i(dly), .dev_i(lk_o), .to_dev_o(lk_i));
	// ==========================================================
	// Helpers
	task automatic report_and_stop();
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0, d};
		sel <= 4'h3;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
		begin
			mismatches++;
			$display("BAD %0t no ack", $time);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	function automatic logic probe(input int k);
		case (k)
			0: return lk_o.link_up;
			1: return !lk_o.link_up;
			2: return lk_o.flp_active;
			default: return lk_o.tx_valid;
		endcase
	endfunction
	task automatic wt(input int k);
		int n;
		n = 0;
		while (probe(k) !== 1'b1 && n < 300)
		begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, probe(k)}, 32'h1);
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_defaults();
		logic [7:0] a[9] = '{OFS_CTRL, OFS_ADV, OFS_EXP, OFS_NPT,
			OFS_GCTL, OFS_PSCTL, OFS_FIBER_TX_CONFIG_WORD, OFS_MCTL, 8'h80};
		logic [15:0] v[9] = '{CTRL_RESET, ADV_RESET, EXP_RESET, NPT_RESET,
			GCTL_RESET, PSCTL_RESET, FIBER_TX_CONFIG_WORD_RESET, {13'h0, MCTL_RESET}, 16'h0};
		wb(1'b1, 8'h80, 16'hffff);
		for (int i = 0; i < 9; i++)
		begin
			wb(1'b0, a[i], 16'h0);
			chk(q, {16'h0, v[i]});
		end
	endtask
	task automatic t_gig();
		wt(0);
		chk({28'h0, lk_o.speed, lk_o.full_duplex, lk_o.link_up},
			{28'h0, SPD_1000, 2'b11});
		wb(1'b0, OFS_MSTAT, 16'h0);
		chk(q, {28'h0, SPD_1000, 2'b11});
		wb(1'b0, OFS_STAT, 16'h0);
		chk(q & 32'h20, 32'h20);
		wb(1'b0, OFS_LPA, 16'h0);
		chk(q, 32'h81e1);
		wb(1'b0, OFS_PSSTAT, 16'h0);
		chk(q & 32'h3a, {26'h0, SPD_1000, 4'ha});
		wb(1'b0, OFS_PINT, 16'h0);
		chk(q & 32'h1, 32'h1);
	endtask
	task automatic t_np();
		wb(1'b1, OFS_EXP, 16'h8000);
		wb(1'b1, OFS_NPT, 16'h0123);
		wb(1'b1, OFS_CTRL, 16'h1340);
		wt(1);
		wt(0);
		wb(1'b0, OFS_LPNP, 16'h0);
		chk(q, 32'h0200);
		wb(1'b1, OFS_EXP, 16'h0000);
	endtask
	task automatic t_trig();
		logic [7:0] a[4] = '{OFS_CTRL, OFS_CTRL, OFS_CTRL, OFS_MCTL};
		logic [15:0] d1[4] = '{16'h1340, 16'h9140, 16'h1940, 16'h0002};
		logic [15:0] d2[4] = '{16'h1140, 16'h1140, 16'h1140, 16'h0000};
		for (int i = 0; i < 4; i++)
		begin
			wt(0);
			wb(1'b1, a[i], d1[i]);
			wb(1'b0, a[i], 16'h0);
			chk(q & 32'h8200, 32'h0);
			wb(1'b1, a[i], d2[i]);
			wt(2);
		end
		wt(0);
		wb(1'b1, OFS_MCTL, 16'h0001);
		lowp <= 1'b1;
		wt(2);
		lowp <= 1'b0;
	endtask
	task automatic t_link();
		wt(0);
		dly <= 4'h0;
		up <= 1'b0;
		wt(1);
		wt(2);
		up <= 1'b1;
		wt(0);
	endtask
	task automatic t_pdet();
		an <= 1'b0;
		wb(1'b1, OFS_CTRL, 16'h1340);
		wt(1);
		wt(0);
		chk({30'h0, lk_o.speed}, {30'h0, SPD_100});
		wb(1'b1, OFS_CTRL, 16'h8000);
		wt(1);
		wt(0);
		chk({30'h0, lk_o.speed, lk_o.full_duplex},
			{29'h0, SPD_10, 1'b0});
		an <= 1'b1;
		wb(1'b1, OFS_CTRL, 16'h9140);
	endtask
	task automatic t_pwr();
		wb(1'b1, OFS_ADV, 16'h0061);
		wb(1'b0, OFS_ADV, 16'h0);
		chk(q, 32'h61);
		pwr <= 1'b0;
		repeat (4) @(posedge clk_i);
		pwr <= 1'b1;
		wb(1'b0, OFS_ADV, 16'h0);
		chk(q, {16'h0, ADV_RESET});
		wt(0);
	endtask
	task automatic t_fiber();
		fib <= 1'b1;
		do_reset();
		wb(1'b1, OFS_FIBER_TX_CONFIG_WORD, 16'h2020);
		wt(0);
		up <= 1'b0;
		wt(1);
		up <= 1'b1;
		wt(0);
		wb(1'b0, OFS_STAT, 16'h0);
		chk(q & 32'h20, 32'h0);
		wb(1'b0, OFS_MSTAT, 16'h0);
		chk(q, {28'h0, SPD_1000, 2'b11});
		wb(1'b1, OFS_FIBER_TX_CONFIG_WORD, FIBER_TX_CONFIG_WORD_RESET);
		wb(1'b1, OFS_MCTL, 16'h0004);
		wt(3);
	endtask
	// ==========================================================
	// Clock, watchdog and main sequence
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial
	begin
		#400000;
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		rst_i = 1'b1;
		{cyc, stb, we, lowp, fib} = 5'h0;
		{adr, sel, dat} = 44'h0;
		{pwr, up, an} = 3'h7;
		spd = SPD_100;
		dly = 4'h9;
		mismatches = 0;
		n_compared = 0;
		@(posedge clk_i);
		do_reset();
		t_defaults();
		t_gig();
		t_np();
		t_trig();
		t_link();
		t_pdet();
		t_pwr();
		t_fiber();
		report_and_stop();
	end
endmodule
